// >>> src/mcs_pkg.sv
package mcs_pkg;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_PH_RATED   = 8'h04;
    localparam logic [7:0]  OFF_EA_RATED   = 8'h08;
    localparam logic [7:0]  OFF_CTS_LIMIT  = 8'h0C;
    localparam logic [7:0]  OFF_LOP_THRESH = 8'h10;
    localparam logic [7:0]  OFF_LOP_DELAY  = 8'h14;
    localparam logic [7:0]  OFF_BLOCK_SEL  = 8'h18;
    localparam logic [7:0]  OFF_STATUS     = 8'h1C;
    localparam logic [7:0]  OFF_INT_STATUS = 8'h20;
    localparam logic [7:0]  OFF_INT_MASK   = 8'h24;
    // Control bit positions
    localparam int CTRL_CTS_EN     = 0;
    localparam int CTRL_LOP_EN     = 1;
    localparam int CTRL_PERMIT     = 2;
    localparam int CTRL_FUSE_EN    = 3;
    localparam int CTRL_BRK_ASSIGN = 4;
    localparam int CTRL_SIDE_SEL   = 5;
    localparam int CTRL_W          = 6;
    // Interrupt bit positions
    localparam int INT_CT_ALARM = 0;
    localparam int INT_LOP      = 1;
    localparam int INT_FUSE     = 2;
    localparam int INT_W        = 3;
    // Reset values
    localparam logic [5:0]  CTRL_RST     = 6'h00;
    localparam logic [31:0] RATED_RST    = 32'h0001_0001;
    localparam logic [31:0] CTS_LIM_RST  = 32'h0000_0100;
    localparam logic [15:0] IN_CODE      = 16'h1000;
    localparam logic [15:0] VN_CODE      = 16'h1000;
    localparam logic [15:0] UV_RST       = 16'h0029;
    localparam logic [31:0] LOP_THR_RST  = {IN_CODE, UV_RST};
    localparam logic [15:0] DELAY_RST    = 16'h000A;
    localparam logic [15:0] KI_RST       = 16'h0100;
    // Fixed condition limits: 1 % of Vn, 0.1 In, 40 % negative ratio
    localparam logic [15:0] VZERO_LIMIT  = 16'h0029;
    localparam logic [15:0] IRES_LIMIT   = 16'h0199;
    localparam logic [7:0]  NEG_PCT      = 8'h28;
    localparam logic [7:0]  FULL_PCT     = 8'h64;
    // Ratio factor fraction bits and divider step count
    localparam int          KI_FRAC      = 8;
    localparam logic [5:0]  DIV_STEPS    = 6'h28;
endpackage

// >>> src/mcs_top.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
module mcs_top (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Measurement update, side A phase and earth phasors
    input  wire logic               meas_valid,
    input  wire logic signed [15:0] i_re [0:2],
    input  wire logic signed [15:0] i_im [0:2],
    input  wire logic signed [15:0] ig_re,
    input  wire logic signed [15:0] ig_im,
    input  wire logic        [15:0] i_mag [0:2],
    // Per winding side magnitudes for potential-loss supervision
    input  wire logic        [15:0] side_v_min [0:1],
    input  wire logic        [15:0] side_v_zero [0:1],
    input  wire logic        [15:0] side_v_neg [0:1],
    input  wire logic        [15:0] side_v_pos [0:1],
    input  wire logic        [15:0] side_i_max [0:1],
    input  wire logic        [15:0] side_i_res [0:1],
    // Same-clock status from other logic
    input  wire logic [7:0]         oc_pickup,
    input  wire logic               dead_bus,
    // Digital input pins
    input  wire logic               external_fuse_fail_input,
    input  wire logic               breaker_closed_pin,
    // Outputs
    output logic                    ct_fail_alarm,
    output logic                    potential_loss_block,
    output logic [7:0]              element_block,
    output logic                    irq
);
    logic [5:0]  ctrl_q;
    logic [31:0] ph_rated_q, ea_rated_q, cts_lim_q, lop_thr_q;
    logic [15:0] delay_q, block_sel_q, ki_q, lop_cnt_q;
    logic [2:0]  int_stat_q, int_mask_q;
    logic [31:0] prdata_q;
    logic        ct_alarm_q, lop_block_q, lop_cond_q;
    logic [1:0]  fuse_sync_q, brk_sync_q;
    logic        ct_prev_q, lop_prev_q, fuse_prev_q;
    logic        ki_start_q, ki_busy_q;
    logic [5:0]  div_cnt_q;
    logic [39:0] div_q;
    logic [32:0] rem_q;
    logic [31:0] den_q;

    // Bus decode
    wire setup_ph = psel & ~penable;
    wire wr_acc   = psel & penable & pwrite;
    wire hit_ctrl = paddr == mcs_pkg::OFF_CTRL;
    wire hit_ph   = paddr == mcs_pkg::OFF_PH_RATED;
    wire hit_ea   = paddr == mcs_pkg::OFF_EA_RATED;
    wire hit_lim  = paddr == mcs_pkg::OFF_CTS_LIMIT;
    wire hit_thr  = paddr == mcs_pkg::OFF_LOP_THRESH;
    wire hit_dly  = paddr == mcs_pkg::OFF_LOP_DELAY;
    wire hit_bsel = paddr == mcs_pkg::OFF_BLOCK_SEL;
    wire hit_stat = paddr == mcs_pkg::OFF_STATUS;
    wire hit_ist  = paddr == mcs_pkg::OFF_INT_STATUS;
    wire hit_imsk = paddr == mcs_pkg::OFF_INT_MASK;
    wire hit_any  = hit_ctrl | hit_ph | hit_ea | hit_lim | hit_thr | hit_dly
                  | hit_bsel | hit_stat | hit_ist | hit_imsk;

    wire fuse_fail  = fuse_sync_q[1] & ctrl_q[mcs_pkg::CTRL_FUSE_EN];
    wire brk_closed = brk_sync_q[1];
    wire side       = ctrl_q[mcs_pkg::CTRL_SIDE_SEL];

    wire [31:0] rd_mux =
        hit_ctrl ? {26'h0, ctrl_q} :
        hit_ph   ? ph_rated_q :
        hit_ea   ? ea_rated_q :
        hit_lim  ? cts_lim_q :
        hit_thr  ? lop_thr_q :
        hit_dly  ? {16'h0, delay_q} :
        hit_bsel ? {16'h0, block_sel_q} :
        hit_stat ? {ki_q, 11'h0, ki_busy_q, lop_cond_q, fuse_fail,
                    lop_block_q, ct_alarm_q} :
        hit_ist  ? {29'h0, int_stat_q} :
        hit_imsk ? {29'h0, int_mask_q} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_any;
    assign prdata  = prdata_q;

    // Residual sum of phasors plus scaled earth current
    wire signed [16:0] ki_s      = $signed({1'b0, ki_q});
    wire signed [32:0] kig_re_p  = ki_s * ig_re;
    wire signed [32:0] kig_im_p  = ki_s * ig_im;
    wire signed [24:0] kig_re    = kig_re_p[32:8];
    wire signed [24:0] kig_im    = kig_im_p[32:8];
    wire signed [25:0] res_re    = 26'(i_re[0]) + 26'(i_re[1]) + 26'(i_re[2])
                                 + 26'(kig_re);
    wire signed [25:0] res_im    = 26'(i_im[0]) + 26'(i_im[1]) + 26'(i_im[2])
                                 + 26'(kig_im);
    wire        [51:0] res_sq_re = 52'(res_re * res_re);
    wire        [51:0] res_sq_im = 52'(res_im * res_im);
    wire        [52:0] res_sq    = 53'(res_sq_re) + 53'(res_sq_im);

    wire [15:0] imax01   = (i_mag[0] > i_mag[1]) ? i_mag[0] : i_mag[1];
    wire [15:0] imax     = (imax01 > i_mag[2]) ? imax01 : i_mag[2];
    wire [31:0] kd_imax  = cts_lim_q[31:16] * imax;
    wire [24:0] limit    = 25'(cts_lim_q[15:0]) + 25'(kd_imax[31:8]);
    wire [49:0] limit_sq = 50'(limit * limit);
    wire        ct_cond  = ctrl_q[mcs_pkg::CTRL_CTS_EN]
                         & (res_sq >= 53'(limit_sq));

    // Potential-loss condition on the selected winding side
    wire [23:0] neg_sc   = side_v_neg[side] * mcs_pkg::FULL_PCT;
    wire [23:0] pos_sc   = side_v_pos[side] * mcs_pkg::NEG_PCT;
    wire        v_low    = side_v_min[side] < lop_thr_q[15:0];
    wire        zero_ok  = (side_v_zero[side] < mcs_pkg::VZERO_LIMIT) | (neg_sc > pos_sc);
    wire        i_low    = side_i_max[side] < lop_thr_q[31:16];
    wire        ires_low = side_i_res[side] < mcs_pkg::IRES_LIMIT;
    wire        oc_block = |(oc_pickup & block_sel_q[7:0]);
    wire        brk_ok   = brk_closed | ~ctrl_q[mcs_pkg::CTRL_BRK_ASSIGN];
    wire        lop_cond = ctrl_q[mcs_pkg::CTRL_LOP_EN] & v_low & zero_ok & i_low
                         & ires_low & ~oc_block & brk_ok & ~dead_bus;

    wire        lop_fwd  = lop_block_q & ctrl_q[mcs_pkg::CTRL_PERMIT];
    assign element_block        = block_sel_q[15:8] & {8{lop_fwd | fuse_fail}};
    assign ct_fail_alarm        = ct_alarm_q;
    assign potential_loss_block = lop_block_q;
    assign irq                  = |(int_stat_q & int_mask_q);

    // Ratio factor divider step
    wire [32:0] rem_sh  = {rem_q[31:0], div_q[39]};
    wire        rem_ge  = rem_sh >= {1'b0, den_q};
    wire [32:0] rem_nx  = rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
    wire [31:0] ki_num  = ea_rated_q[31:16] * ph_rated_q[15:0];
    wire [31:0] ki_den  = ea_rated_q[15:0] * ph_rated_q[31:16];
    wire        ki_sat  = (den_q == 32'h0) | (|div_q[39:16]);

    wire [2:0]  ev      = {fuse_fail & ~fuse_prev_q, lop_block_q & ~lop_prev_q,
                           ct_alarm_q & ~ct_prev_q};
    wire [2:0]  ist_clr = (wr_acc & hit_ist) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fuse_sync_q <= 2'h0;
            brk_sync_q  <= 2'h0;
        end else begin
            fuse_sync_q <= {fuse_sync_q[0], external_fuse_fail_input};
            brk_sync_q  <= {brk_sync_q[0], breaker_closed_pin};
        end
    end

    // Register file
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q      <= mcs_pkg::CTRL_RST;
            ph_rated_q  <= mcs_pkg::RATED_RST;
            ea_rated_q  <= mcs_pkg::RATED_RST;
            cts_lim_q   <= mcs_pkg::CTS_LIM_RST;
            lop_thr_q   <= mcs_pkg::LOP_THR_RST;
            delay_q     <= mcs_pkg::DELAY_RST;
            block_sel_q <= 16'h0000;
            int_mask_q  <= 3'h0;
            prdata_q    <= 32'h0000_0000;
        end else begin
            if (setup_ph) begin
                prdata_q <= rd_mux;
            end
            if (wr_acc & hit_ctrl) ctrl_q      <= pwdata[5:0];
            if (wr_acc & hit_ph)   ph_rated_q  <= pwdata;
            if (wr_acc & hit_ea)   ea_rated_q  <= pwdata;
            if (wr_acc & hit_lim)  cts_lim_q   <= pwdata;
            if (wr_acc & hit_thr)  lop_thr_q   <= pwdata;
            if (wr_acc & hit_dly)  delay_q     <= pwdata[15:0];
            if (wr_acc & hit_bsel) block_sel_q <= pwdata[15:0];
            if (wr_acc & hit_imsk) int_mask_q  <= pwdata[2:0];
        end
    end

    // Sticky event flags, a new event beats a same-cycle clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            int_stat_q  <= 3'h0;
            ct_prev_q   <= 1'b0;
            lop_prev_q  <= 1'b0;
            fuse_prev_q <= 1'b0;
        end else begin
            int_stat_q  <= (int_stat_q & ~ist_clr) | ev;
            ct_prev_q   <= ct_alarm_q;
            lop_prev_q  <= lop_block_q;
            fuse_prev_q <= fuse_fail;
        end
    end

    // Ratio factor: earth ratio over phase ratio, recomputed after rated writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ki_q       <= mcs_pkg::KI_RST;
            ki_start_q <= 1'b0;
            ki_busy_q  <= 1'b0;
            div_cnt_q  <= 6'h00;
            div_q      <= 40'h0;
            rem_q      <= 33'h0;
            den_q      <= 32'h0;
        end else begin
            ki_start_q <= wr_acc & (hit_ph | hit_ea);
            if (ki_start_q) begin
                ki_busy_q <= 1'b1;
                div_cnt_q <= 6'h00;
                div_q     <= {ki_num, 8'h00};
                rem_q     <= 33'h0;
                den_q     <= ki_den;
            end else if (ki_busy_q) begin
                if (div_cnt_q == mcs_pkg::DIV_STEPS) begin
                    ki_busy_q <= 1'b0;
                    ki_q      <= ki_sat ? 16'hFFFF : div_q[15:0];
                end else begin
                    div_cnt_q <= div_cnt_q + 6'h01;
                    rem_q     <= rem_nx;
                    div_q     <= {div_q[38:0], rem_ge};
                end
            end
        end
    end

    // Supervision evaluated once per measurement update
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ct_alarm_q  <= 1'b0;
            lop_block_q <= 1'b0;
            lop_cond_q  <= 1'b0;
            lop_cnt_q   <= 16'h0000;
        end else if (meas_valid) begin
            ct_alarm_q <= ct_cond;
            lop_cond_q <= lop_cond;
            if (!lop_cond) begin
                lop_cnt_q   <= 16'h0000;
                lop_block_q <= 1'b0;
            end else if (lop_cnt_q < delay_q) begin
                lop_cnt_q   <= lop_cnt_q + 16'h0001;
            end else begin
                lop_block_q <= 1'b1;
            end
        end
    end
endmodule

// >>> sim/mcs_monitor.sv
`timescale 1ns/1ns
module mcs_monitor (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // Register bus
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Supervision
    input wire logic       meas_valid,
    input wire logic       dead_bus,
    input wire logic       ct_fail_alarm,
    input wire logic       potential_loss_block
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_ct_hold: assert property (!$past(meas_valid) && !$past(meas_valid, 2)
        |-> $stable(ct_fail_alarm)) else $error("ct alarm moved between updates");
    chk_loss_hold: assert property (!$past(meas_valid)
        |-> $stable(potential_loss_block)) else $error("loss block moved between updates");
    chk_loss_rise: assert property ($rose(potential_loss_block) |-> $past(meas_valid))
        else $error("loss block rose without an update");
    chk_dead_clear: assert property (meas_valid && dead_bus |=> !potential_loss_block)
        else $error("loss block set with dead busbar");
    chk_rise_live: assert property ($rose(potential_loss_block) |-> !$past(dead_bus))
        else $error("loss block rose on dead busbar");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    chk_ready_access: assert property (psel && penable |-> pready)
        else $error("access not answered");
endmodule

bind mcs_top mcs_monitor mcs_monitor_i (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .dead_bus(dead_bus), .ct_fail_alarm(ct_fail_alarm),
    .potential_loss_block(potential_loss_block));

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic               ref_clk = 1'b0;
    logic               rst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic [31:0]        rdata;
    logic               pready;
    logic               pslverr;
    logic               meas_valid = 1'b0;
    logic signed [15:0] i_re [0:2];
    logic signed [15:0] i_im [0:2];
    logic signed [15:0] ig_re = 16'h0000;
    logic signed [15:0] ig_im = 16'h0000;
    logic [15:0]        i_mag [0:2];
    logic [15:0]        side_v_min [0:1], side_v_zero [0:1], side_v_neg [0:1];
    logic [15:0]        side_v_pos [0:1], side_i_max [0:1], side_i_res [0:1];
    logic [7:0]         oc_pickup = 8'h00;
    logic               dead_bus = 1'b0;
    logic               fuse_pin = 1'b0;
    logic               ct_fail_alarm;
    logic               potential_loss_block;
    logic [7:0]         element_block;
    logic               irq;
    int                 errors = 0;
    int                 checks_done = 0;
    int                 cycles = 0;

    always #50 ref_clk = ~ref_clk;

    mcs_top mcs_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_valid(meas_valid), .i_re(i_re), .i_im(i_im),
        .ig_re(ig_re), .ig_im(ig_im), .i_mag(i_mag), .side_v_min(side_v_min),
        .side_v_zero(side_v_zero), .side_v_neg(side_v_neg), .side_v_pos(side_v_pos),
        .side_i_max(side_i_max), .side_i_res(side_i_res), .oc_pickup(oc_pickup),
        .dead_bus(dead_bus), .external_fuse_fail_input(fuse_pin),
        .breaker_closed_pin(1'b1), .ct_fail_alarm(ct_fail_alarm),
        .potential_loss_block(potential_loss_block), .element_block(element_block),
        .irq(irq));

    task automatic test_done();
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps a following call from re-driving psel in this step
        @(posedge ref_clk);
    endtask

    task automatic upd();
        meas_valid <= 1'b1;
        @(posedge ref_clk);
        meas_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check(rdata, 32'h0000_000A);
        apb(1'b0, 8'h0C, 32'h0);
        check(rdata, 32'h0000_0100);
        apb(1'b0, 8'h1C, 32'h0);
        check(rdata, 32'h0100_0000);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        apb(1'b0, 8'h40, 32'h0);
        check(rdata, 32'h0);
    endtask

    task automatic t_ct();
        apb(1'b1, 8'h00, 32'h1);
        ig_re <= 16'h00FF;
        upd();
        check(32'(ct_fail_alarm), 32'h0);
        ig_re <= 16'h0100;
        upd();
        check(32'(ct_fail_alarm), 32'h1);
        apb(1'b1, 8'h0C, 32'h0100_0100);
        upd();
        check(32'(ct_fail_alarm), 32'h0);
        ig_re <= 16'h0200;
        upd();
        check(32'(ct_fail_alarm), 32'h1);
        ig_re <= 16'h0000;
        upd();
        check(32'(ct_fail_alarm), 32'h0);
    endtask

    task automatic t_lop();
        apb(1'b1, 8'h14, 32'h2);
        apb(1'b1, 8'h18, 32'h0000_0101);
        apb(1'b1, 8'h00, 32'h6);
        repeat (2) begin
            upd();
            check(32'(potential_loss_block), 32'h0);
        end
        upd();
        check(32'(potential_loss_block), 32'h1);
        check(32'(element_block), 32'h01);
        check(32'(irq), 32'h0);
        apb(1'b1, 8'h24, 32'h2);
        @(posedge ref_clk);
        check(32'(irq), 32'h1);
        apb(1'b1, 8'h20, 32'h2);
        @(posedge ref_clk);
        check(32'(irq), 32'h0);
        oc_pickup <= 8'h01;
        upd();
        check(32'(potential_loss_block), 32'h0);
        oc_pickup <= 8'h00;
        dead_bus <= 1'b1;
        upd();
        check(32'(potential_loss_block), 32'h0);
        dead_bus <= 1'b0;
        apb(1'b1, 8'h00, 32'h2);
        repeat (3) upd();
        check(32'(potential_loss_block), 32'h1);
        check(32'(element_block), 32'h0);
        apb(1'b1, 8'h00, 32'h22);
        upd();
        check(32'(potential_loss_block), 32'h0);
    endtask

    task automatic t_fuse();
        apb(1'b1, 8'h00, 32'h28);
        fuse_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(32'(element_block), 32'h01);
        fuse_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(32'(element_block), 32'h0);
    endtask

    task automatic t_ratio();
        apb(1'b1, 8'h04, 32'h0002_0001);
        repeat (45) @(posedge ref_clk);
        apb(1'b0, 8'h1C, 32'h0);
        check(32'(rdata[31:16]), 32'h0080);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        i_re = '{16'h0100, 16'hFF80, 16'hFF80};
        i_im = '{16'h0000, 16'h006E, 16'hFF92};
        i_mag = '{3{16'h0100}};
        side_v_min = '{16'h0000, 16'hFFFF};
        side_v_zero = '{2{16'h0000}};
        side_v_neg = '{2{16'h0000}};
        side_v_pos = '{2{16'h0000}};
        side_i_max = '{2{16'h0000}};
        side_i_res = '{2{16'h0000}};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_ct();
        t_lop();
        t_fuse();
        t_ratio();
        test_done();
    end
endmodule
